/* File: rtl/vmis_input_stage.sv */
// Pixel input stage of the video mixer: capture, look-up, crosspoint, mix.
//
// The implementer's own choices: the AHB-Lite slave port and the register offsets.
`include "vmis_defs.svh"

// What this block does
// - Capture all pixel inputs on rising edge.
// - One clock paces datapath and coefficient.
// - Mask A pixel, then address the tables.
// - Bypass passes A pixel untranslated.
// - Index mode: low byte addresses all sections.
// - B pixel through optional conversion, interpolation.
// - Coefficient captured each clock sets mix.
// - Coefficient top bit keys first versus second operand in key mode.
// - Field all ones: pins steer crosspoint.
// - Crosspoint routes A, B or fill.
// - Other field values ignore select pins.
// - Select pins sampled with pixel data.
// - Mixed output fourteen clocks after capture.
module vmis_input_stage
  import vmis_pkg::*;
#(
  parameter int PIX_W = 24,
  parameter int LATENCY = `VMIS_LATENCY
) (
  input  wire logic              hclk,
  input  wire logic              hresetn,
  input  wire logic              ce,
  input  wire logic              hsel,
  input  wire logic [31:0]       haddr,
  input  wire logic [1:0]        htrans,
  input  wire logic              hwrite,
  input  wire logic [2:0]        hsize,
  input  wire logic [31:0]       hwdata,
  input  wire logic              hready,
  output logic                   hreadyout,
  output logic                   hresp,
  output logic [31:0]            hrdata,
  input  wire logic [PIX_W-1:0]  chan_a_pixel_in,
  input  wire logic [PIX_W-1:0]  chan_b_pixel_in,
  input  wire logic [8:0]        alpha_in,
  input  wire logic [2:0]        xpoint_select_in,
  output logic [PIX_W-1:0]       mixed_pixel_out
);

  localparam int TAIL = LATENCY - `VMIS_HEAD_STAGES;

  // --------------------------------------------------------------------------
  // Bus slave
  // --------------------------------------------------------------------------
  logic              dph_wr_q;
  logic [31:0]       dph_addr_q;
  logic [31:0]       rd_d;
  logic [31:0]       hrdata_q;
  logic [7:0]        ctrl_q;
  vmis_pixel_t       mask_q;
  vmis_pixel_t       fill_q;
  logic [7:0]        lut_addr_q;
  logic              res_seen_q;
  logic              lut_wr;
  logic              stat_clr;
  logic [2:0]        sel_q;
  logic [8:0]        alpha_q;

  // Zero wait states; a low clock enable stalls the bus with the datapath.
  assign hreadyout = ce;
  assign hresp     = 1'b0;
  assign hrdata    = hrdata_q;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dph_wr_q   <= 1'b0;
      dph_addr_q <= 32'h0000_0000;
    end else if (ce && hready) begin
      dph_wr_q   <= hsel && htrans[1] && hwrite;
      dph_addr_q <= haddr;
    end
  end

  always_comb begin
    rd_d = 32'h0000_0000;
    if (haddr == `VMIS_CTRL_OFS) begin
      rd_d = {24'h00_0000, ctrl_q};
    end else if (haddr == `VMIS_MASK_OFS) begin
      rd_d = {8'h00, mask_q};
    end else if (haddr == `VMIS_FILL_OFS) begin
      rd_d = {8'h00, fill_q};
    end else if (haddr == `VMIS_LUTADR_OFS) begin
      rd_d = {24'h00_0000, lut_addr_q};
    end else if (haddr == `VMIS_STAT_OFS) begin
      rd_d = {27'h000_0000, alpha_q[8], res_seen_q, sel_q};
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata_q <= 32'h0000_0000;
    end else if (ce && hready && hsel && htrans[1] && !hwrite) begin
      hrdata_q <= rd_d;
    end
  end

  assign lut_wr   = dph_wr_q && (dph_addr_q == `VMIS_LUTDAT_OFS);
  assign stat_clr = dph_wr_q && (dph_addr_q == `VMIS_STAT_OFS) && hwdata[`VMIS_STAT_RES];

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl_q     <= `VMIS_CTRL_RST;
      mask_q     <= `VMIS_MASK_RST;
      fill_q     <= `VMIS_FILL_RST;
      lut_addr_q <= 8'h00;
    end else if (ce && dph_wr_q) begin
      if (dph_addr_q == `VMIS_CTRL_OFS) begin
        ctrl_q <= hwdata[7:0];
      end else if (dph_addr_q == `VMIS_MASK_OFS) begin
        mask_q <= hwdata[23:0];
      end else if (dph_addr_q == `VMIS_FILL_OFS) begin
        fill_q <= hwdata[23:0];
      end else if (dph_addr_q == `VMIS_LUTADR_OFS) begin
        lut_addr_q <= hwdata[7:0];
      end else if (dph_addr_q == `VMIS_LUTDAT_OFS) begin
        lut_addr_q <= lut_addr_q + 8'h01;
      end
    end
  end

  // --------------------------------------------------------------------------
  // Stage 0: input capture
  // --------------------------------------------------------------------------
  vmis_pixel_t       a_q;
  vmis_pixel_t       b_q;
  logic [2:0]        xp_cfg;
  assign xp_cfg = ctrl_q[`VMIS_CTRL_XP_HI:`VMIS_CTRL_XP_LO];
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      a_q     <= 24'h00_0000;
      b_q     <= 24'h00_0000;
      alpha_q <= 9'h000;
      sel_q   <= 3'h0;
    end else if (ce) begin
      a_q     <= chan_a_pixel_in;
      b_q     <= chan_b_pixel_in;
      alpha_q <= alpha_in;
      sel_q   <= (xp_cfg == `VMIS_XP_PINS) ? xpoint_select_in : xp_cfg;
    end
  end

  // --------------------------------------------------------------------------
  // Stage 1: mask and colour conversion
  // --------------------------------------------------------------------------
  vmis_pixel_t       a_idx_q;
  vmis_pixel_t       b_c_q;
  logic [8:0]        alpha1_q;
  logic [2:0]        sel1_q;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      a_idx_q  <= 24'h00_0000;
      b_c_q    <= 24'h00_0000;
      alpha1_q <= 9'h000;
      sel1_q   <= 3'h0;
    end else if (ce) begin
      a_idx_q  <= a_q & mask_q;
      // Conversion turns offset-binary chroma into two's complement.
      b_c_q    <= ctrl_q[`VMIS_CTRL_CSC] ? (b_q ^ 24'h80_0080) : b_q;
      alpha1_q <= alpha_q;
      sel1_q   <= sel_q;
    end
  end

  // --------------------------------------------------------------------------
  // Stage 2: colour look-up and interpolation
  // --------------------------------------------------------------------------
  vmis_pixel_t       a_lut_q;
  vmis_pixel_t       b_i_q;
  vmis_pixel_t       b_prev_q;
  logic [8:0]        alpha2_q;
  logic [2:0]        sel2_q;

  for (genvar g = 0; g < 3; g++) begin : sec
    logic [7:0] mem [256];
    logic [7:0] rd_addr;
    // In index mode every section is addressed by the low byte.
    assign rd_addr = ctrl_q[`VMIS_CTRL_INDEX] ? a_idx_q[7:0] : a_idx_q[g*8 +: 8];
    always_ff @(posedge hclk) begin
      if (ce && lut_wr) begin
        mem[lut_addr_q] <= hwdata[g*8 +: 8];
      end
    end
    always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
        a_lut_q[g*8 +: 8] <= 8'h00;
      end else if (ce) begin
        a_lut_q[g*8 +: 8] <= ctrl_q[`VMIS_CTRL_BYPASS] ? a_idx_q[g*8 +: 8]
                                                       : mem[rd_addr];
      end
    end
  end

  // Interpolation averages chroma with the previous pixel; luma passes.
  logic [8:0]        cr_sum;
  logic [8:0]        cb_sum;
  assign cr_sum = {1'b0, b_c_q[23:16]} + {1'b0, b_prev_q[23:16]};
  assign cb_sum = {1'b0, b_c_q[7:0]} + {1'b0, b_prev_q[7:0]};
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      b_i_q    <= 24'h00_0000;
      b_prev_q <= 24'h00_0000;
      alpha2_q <= 9'h000;
      sel2_q   <= 3'h0;
    end else if (ce) begin
      b_prev_q <= b_c_q;
      b_i_q    <= ctrl_q[`VMIS_CTRL_INTERP] ? {cr_sum[8:1], b_c_q[15:8], cb_sum[8:1]}
                                            : b_c_q;
      alpha2_q <= alpha1_q;
      sel2_q   <= sel1_q;
    end
  end

  // --------------------------------------------------------------------------
  // Stage 3: crosspoint and effective coefficient
  // --------------------------------------------------------------------------
  vmis_src_t         src1;
  vmis_src_t         src2;
  logic              sel_res;
  vmis_pixel_t       v1_q;
  vmis_pixel_t       v2_q;
  logic [8:0]        al_q;
  logic [8:0]        al_d;
  logic [5:0]        route;

  always_comb begin
    sel_res = 1'b0;
    route   = {VMIS_SRC_A, VMIS_SRC_B};
    case (sel2_q)
      3'b000:  route = {VMIS_SRC_A, VMIS_SRC_B};
      3'b001:  route = {VMIS_SRC_A, VMIS_SRC_F};
      3'b010:  route = {VMIS_SRC_B, VMIS_SRC_A};
      3'b011:  route = {VMIS_SRC_B, VMIS_SRC_F};
      3'b100:  route = {VMIS_SRC_F, VMIS_SRC_A};
      3'b101:  route = {VMIS_SRC_F, VMIS_SRC_B};
      default: sel_res = 1'b1;
    endcase
  end

  assign src1 = vmis_src_t'(route[5:3]);
  assign src2 = vmis_src_t'(route[2:0]);

  // Key mode forces a full cut; otherwise the coefficient saturates at unity.
  assign al_d = alpha2_q[8] ? `VMIS_UNITY
              : ctrl_q[`VMIS_CTRL_KEY] ? 9'h000 : alpha2_q;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      v1_q <= 24'h00_0000;
      v2_q <= 24'h00_0000;
      al_q <= 9'h000;
    end else if (ce) begin
      v1_q <= (src1 == VMIS_SRC_A) ? a_lut_q : (src1 == VMIS_SRC_B) ? b_i_q : fill_q;
      v2_q <= (src2 == VMIS_SRC_A) ? a_lut_q : (src2 == VMIS_SRC_B) ? b_i_q : fill_q;
      al_q <= al_d;
    end
  end

  // A reserved code sets a sticky flag; a set wins over a clear.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      res_seen_q <= 1'b0;
    end else if (ce && (sel_res || stat_clr)) begin
      res_seen_q <= sel_res;
    end
  end

  // --------------------------------------------------------------------------
  // Stages 4 and 5: proportional mix
  // --------------------------------------------------------------------------
  vmis_pixel_t       mix_q;
  logic [16:0]       p1_q [3];
  logic [16:0]       p2_q [3];
  logic [16:0]       psum [3];

  for (genvar c = 0; c < 3; c++) begin : mixc
    assign psum[c] = p1_q[c] + p2_q[c];

    always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
        p1_q[c]          <= 17'h0_0000;
        p2_q[c]          <= 17'h0_0000;
        mix_q[c*8 +: 8]  <= 8'h00;
      end else if (ce) begin
        p1_q[c]          <= {8'h00, al_q} * {9'h000, v1_q[c*8 +: 8]};
        p2_q[c]          <= {8'h00, 9'(`VMIS_UNITY - al_q)} * {9'h000, v2_q[c*8 +: 8]};
        mix_q[c*8 +: 8]  <= psum[c][15:8];
      end
    end
  end

  // --------------------------------------------------------------------------
  // Output delay line
  // --------------------------------------------------------------------------
  vmis_pixel_t       tail_q [TAIL];

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      for (int i = 0; i < TAIL; i++) begin
        tail_q[i] <= 24'h00_0000;
      end
    end else if (ce) begin
      tail_q[0] <= mix_q;
      for (int i = 1; i < TAIL; i++) begin
        tail_q[i] <= tail_q[i-1];
      end
    end
  end

  assign mixed_pixel_out = tail_q[TAIL-1];

  // --------------------------------------------------------------------------
  // Checks
  // --------------------------------------------------------------------------
  logic [3:0]        ce_run_q;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ce_run_q <= 4'h0;
    end else begin
      ce_run_q <= !ce ? 4'h0 : (ce_run_q == 4'hf) ? ce_run_q : ce_run_q + 4'h1;
    end
  end

  capture_pixel_a: assert property (@(posedge hclk) disable iff (!hresetn)
    ce |=> (a_q == $past(chan_a_pixel_in)) && (b_q == $past(chan_b_pixel_in)))
    else $error("pixel inputs not captured");
  coef_capture_a: assert property (@(posedge hclk) disable iff (!hresetn)
    ce |=> alpha_q == $past(alpha_in)) else $error("coefficient not captured");
  mask_index_a: assert property (@(posedge hclk) disable iff (!hresetn)
    ce |=> a_idx_q == ($past(a_q) & $past(mask_q))) else $error("masked index wrong");
  lut_bypass_a: assert property (@(posedge hclk) disable iff (!hresetn)
    (ce && ctrl_q[`VMIS_CTRL_BYPASS]) |=> a_lut_q == $past(a_idx_q))
    else $error("bypass altered pixel");
  index_mode_a: assert property (@(posedge hclk) disable iff (!hresetn)
    (ce && ctrl_q[`VMIS_CTRL_INDEX] && !ctrl_q[`VMIS_CTRL_BYPASS])
    |-> (sec[0].rd_addr == a_idx_q[7:0]) && (sec[2].rd_addr == a_idx_q[7:0]))
    else $error("index mode addressing wrong");
  b_path_a: assert property (@(posedge hclk) disable iff (!hresetn)
    (ce && !ctrl_q[`VMIS_CTRL_CSC]) ##1 (ce && !ctrl_q[`VMIS_CTRL_INTERP])
    |=> b_i_q == $past(b_q, 2)) else $error("plain B path altered pixel");
  key_cut_a: assert property (@(posedge hclk) disable iff (!hresetn)
    (ce && ctrl_q[`VMIS_CTRL_KEY]) |=> al_q == ($past(alpha2_q[8]) ? `VMIS_UNITY : 9'h000))
    else $error("key bit did not cut");
  pin_select_a: assert property (@(posedge hclk) disable iff (!hresetn)
    (ce && xp_cfg == `VMIS_XP_PINS) |=> sel_q == $past(xpoint_select_in))
    else $error("select pins not used");
  pin_ignore_a: assert property (@(posedge hclk) disable iff (!hresetn)
    (ce && xp_cfg != `VMIS_XP_PINS) |=> sel_q == $past(xp_cfg))
    else $error("select pins not ignored");
  fill_route_a: assert property (@(posedge hclk) disable iff (!hresetn)
    (ce && sel2_q == 3'b011) |=> (v1_q == $past(b_i_q)) && (v2_q == $past(fill_q)))
    else $error("crosspoint routing wrong");
  out_latency_a: assert property (@(posedge hclk) disable iff (!hresetn)
    (ce_run_q == 4'hf) |-> mixed_pixel_out == $past(mix_q, 9)) else $error("output latency wrong");

endmodule

/* File: rtl/vmis_defs.svh */
// Offsets, field positions, reset values and timing counts of the mixer input stage.
`ifndef VMIS_DEFS_SVH
`define VMIS_DEFS_SVH

// ----------------------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------------------
`define VMIS_CTRL_OFS      32'h0000_0000
`define VMIS_MASK_OFS      32'h0000_0004
`define VMIS_FILL_OFS      32'h0000_0008
`define VMIS_LUTADR_OFS    32'h0000_000c
`define VMIS_LUTDAT_OFS    32'h0000_0010
`define VMIS_STAT_OFS      32'h0000_0014

// ----------------------------------------------------------------------------
// Control fields
// ----------------------------------------------------------------------------
`define VMIS_CTRL_BYPASS   0
`define VMIS_CTRL_INDEX    1
`define VMIS_CTRL_CSC      2
`define VMIS_CTRL_INTERP   3
`define VMIS_CTRL_KEY      4
`define VMIS_CTRL_XP_LO    5
`define VMIS_CTRL_XP_HI    7
`define VMIS_XP_PINS       3'h7

// ----------------------------------------------------------------------------
// Status fields
// ----------------------------------------------------------------------------
`define VMIS_STAT_SEL_HI   2
`define VMIS_STAT_RES      3
`define VMIS_STAT_KEY      4

// ----------------------------------------------------------------------------
// Reset values and timing
// ----------------------------------------------------------------------------
`define VMIS_CTRL_RST      8'h01
`define VMIS_MASK_RST      24'hff_ffff
`define VMIS_FILL_RST      24'h00_0000
`define VMIS_UNITY         9'h100
`define VMIS_LATENCY       14
`define VMIS_HEAD_STAGES   5

`endif

/* File: rtl/vmis_pkg.sv */
// Types shared by the mixer input stage.
package vmis_pkg;

  typedef logic [23:0] vmis_pixel_t;

  // One-hot source of a mixer operand.
  typedef enum logic [2:0] {
    VMIS_SRC_A = 3'b001,
    VMIS_SRC_B = 3'b010,
    VMIS_SRC_F = 3'b100
  } vmis_src_t;

endpackage

/* File: verification/vmis_pix_src.sv */
// Upstream pixel source model that feeds the mixer input stage one pixel per clock.
module vmis_pix_src
  import vmis_pkg::*;
(
  input  wire logic   hclk,
  output vmis_pixel_t chan_a_pixel_in,
  output vmis_pixel_t chan_b_pixel_in,
  output logic [8:0]  alpha_in,
  output logic [2:0]  xpoint_select_in
);
  timeunit 1ns;
  timeprecision 1ps;

  initial begin
    chan_a_pixel_in = '0;
    chan_b_pixel_in = '0;
    alpha_in = '0;
    xpoint_select_in = '0;
  end

  // The source changes its lines just after an edge so the next edge captures them cleanly.
  task automatic put(input vmis_pixel_t a, input vmis_pixel_t b, input logic [8:0] al,
                     input logic [2:0] sp);
    @(posedge hclk);
    chan_a_pixel_in <= a;
    chan_b_pixel_in <= b;
    alpha_in <= al;
    xpoint_select_in <= sp;
  endtask
endmodule

/* File: verification/tb_top.sv */
// Self-checking bench for the mixer input stage: register access and pixel stream checks.
module tb_top;
  import vmis_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;

  logic        hclk = 1'b0;
  logic        hresetn = 1'b0;
  logic        ce = 1'b1;
  logic        hsel = 1'b0;
  logic [31:0] haddr = '0;
  logic [1:0]  htrans = '0;
  logic        hwrite = 1'b0;
  logic [2:0]  hsize = 3'h2;
  logic [31:0] hwdata = '0;
  logic        hreadyout;
  logic        hresp;
  logic [31:0] hrdata;
  vmis_pixel_t a_in, b_in, mixed;
  logic [8:0]  al_in;
  logic [2:0]  sp_in;
  int          bad_count = 0;
  int          n_tests = 0;
  logic [7:0]  lut_r [256];
  logic [7:0]  lut_g [256];
  logic [7:0]  lut_b [256];
  logic [31:0] ctrl_v = 32'h01;
  logic [31:0] mask_v = 32'hff_ffff;
  logic [31:0] fill_v = 32'h0;
  logic [31:0] rd_v;
  vmis_pixel_t prev_c;
  logic [8:0]  alist [6] = '{9'h100, 9'h000, 9'h080, 9'h1ff, 9'h040, 9'h0c3};
  int          s1 [8] = '{0, 0, 1, 1, 2, 2, 0, 0};
  int          s2 [8] = '{1, 2, 0, 2, 0, 1, 1, 1};

  initial begin
    forever #20 hclk = ~hclk;
  end

  vmis_pix_src src (
    .hclk             (hclk),
    .chan_a_pixel_in  (a_in),
    .chan_b_pixel_in  (b_in),
    .alpha_in         (al_in),
    .xpoint_select_in (sp_in)
  );

  vmis_input_stage dut (
    .hclk             (hclk),
    .hresetn          (hresetn),
    .ce               (ce),
    .hsel             (hsel),
    .haddr            (haddr),
    .htrans           (htrans),
    .hwrite           (hwrite),
    .hsize            (hsize),
    .hwdata           (hwdata),
    .hready           (hreadyout),
    .hreadyout        (hreadyout),
    .hresp            (hresp),
    .hrdata           (hrdata),
    .chan_a_pixel_in  (a_in),
    .chan_b_pixel_in  (b_in),
    .alpha_in         (al_in),
    .xpoint_select_in (sp_in),
    .mixed_pixel_out  (mixed)
  );

  task automatic give_verdict();
    $display("tests %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    n_tests++;
    if (got !== exp) begin
      $display("mismatch %s expected %h seen %h", nm, exp, got);
      bad_count++;
    end
  endtask

  // Waits for hready at a rising edge; a bus that never answers ends the run.
  task automatic wait_rdy();
    int t;
    t = 0;
    do begin
      @(posedge hclk);
      t++;
    end while (hready_ok() == 1'b0 && t < 50);
    if (!hready_ok()) begin
      $display("mismatch bus_ready expected 1 seen timeout");
      bad_count++;
      give_verdict();
    end
  endtask

  function automatic logic hready_ok();
    return hreadyout === 1'b1;
  endfunction

  task automatic bus(input logic wr, input logic [31:0] adr, input logic [31:0] wd);
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= adr;
    htrans <= 2'h2;
    hwrite <= wr;
    hsize <= 3'h2;
    wait_rdy();
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    wait_rdy();
    rd_v = hrdata;
  endtask

  task automatic rdchk(input string nm, input logic [31:0] adr, input logic [31:0] exp);
    bus(1'b0, adr, 32'h0);
    chk(nm, exp, rd_v);
  endtask

  function automatic vmis_pixel_t mixv(vmis_pixel_t a, vmis_pixel_t b, logic [8:0] al,
                                       logic [2:0] sp);
    vmis_pixel_t ta;
    vmis_pixel_t v [3];
    vmis_pixel_t r;
    logic [2:0]  code;
    int          w;
    vmis_pixel_t cb;
    ta = a & mask_v[23:0];
    if (!ctrl_v[0]) begin
      if (ctrl_v[1]) ta = {lut_r[ta[7:0]], lut_g[ta[7:0]], lut_b[ta[7:0]]};
      else ta = {lut_r[ta[23:16]], lut_g[ta[15:8]], lut_b[ta[7:0]]};
    end
    v[0] = ta;
    cb = ctrl_v[2] ? (b ^ 24'h80_0080) : b;
    v[1] = cb;
    if (ctrl_v[3]) begin
      v[1][23:16] = 8'((9'(cb[23:16]) + 9'(prev_c[23:16])) >> 1);
      v[1][7:0] = 8'((9'(cb[7:0]) + 9'(prev_c[7:0])) >> 1);
    end
    prev_c = cb;
    v[2] = fill_v[23:0];
    code = (ctrl_v[7:5] == 3'h7) ? sp : ctrl_v[7:5];
    w = al[8] ? 256 : (ctrl_v[4] ? 0 : int'(al));
    for (int k = 0; k < 3; k++) begin
      r[8*k+:8] = 8'((w * v[s1[code]][8*k+:8] + (256 - w) * v[s2[code]][8*k+:8]) >> 8);
    end
    return r;
  endfunction

  // Streams n varied pixels and compares each result fourteen clock-enabled edges after capture.
  task automatic stream(input string nm, input int n);
    vmis_pixel_t ev [$];
    vmis_pixel_t a, b;
    // The idle pixel ahead of the stream is zero, seen through the current conversion.
    prev_c = ctrl_v[2] ? 24'h80_0080 : 24'h0;
    for (int i = 0; i < n + 15; i++) begin
      a = {8'(i * 37 + 5), 8'(i * 91 + 17), 8'(250 - i * 13)};
      b = {8'(i * 53 + 9), 8'(200 - i * 7), 8'(i * 29 + 1)};
      if (i < n) begin
        ev.push_back(mixv(a, b, alist[i % 6], 3'(i)));
        src.put(a, b, alist[i % 6], 3'(i));
      end else begin
        src.put('0, '0, '0, 3'h0);
      end
      if (n == 30 && i == 20) ce <= 1'b0;
      #1;
      if (i >= 15) chk(nm, {8'h0, ev[i - 15]}, {8'h0, mixed});
      if (n == 30 && i == 20) begin
        repeat (2) @(posedge hclk);
        ce <= 1'b1;
        #1;
        chk("ce_hold", {8'h0, ev[i - 15]}, {8'h0, mixed});
      end
    end
    $display("test %s done", nm);
  endtask

  task automatic set_ctrl(input logic [31:0] v);
    ctrl_v = v;
    bus(1'b1, 32'h00, v);
  endtask

  initial begin
    repeat (5) @(posedge hclk);
    hresetn <= 1'b1;
    rdchk("ctrl_reset", 32'h00, 32'h01);
    chk("hresp_okay", 32'h0, {31'h0, hresp});
    rdchk("mask_reset", 32'h04, 32'hff_ffff);
    rdchk("fill_reset", 32'h08, 32'h0);
    rdchk("unmapped", 32'h40, 32'h0);
    fill_v = 32'h12_3456;
    bus(1'b1, 32'h08, fill_v);
    rdchk("fill_rw", 32'h08, fill_v);
    stream("basic", 30);
    for (int c = 0; c < 6; c++) begin
      set_ctrl({24'h0, 3'(c), 5'h01});
      stream("cfg_code", 8);
    end
    set_ctrl(32'he1);
    stream("pins", 24);
    bus(1'b0, 32'h14, 32'h0);
    chk("stat_reserved", 32'h8, rd_v & 32'h8);
    bus(1'b1, 32'h14, 32'h8);
    bus(1'b0, 32'h14, 32'h0);
    chk("stat_clear", 32'h0, rd_v & 32'h8);
    set_ctrl(32'h01);
    stream("pins_ignored", 24);
    bus(1'b0, 32'h14, 32'h0);
    chk("stat_ignored", 32'h0, rd_v);
    set_ctrl(32'h11);
    stream("key", 24);
    set_ctrl(32'h05);
    stream("conversion", 24);
    set_ctrl(32'h0d);
    stream("interp", 24);
    bus(1'b1, 32'h0c, 32'h0);
    for (int i = 0; i < 256; i++) begin
      lut_r[i] = ~8'(i);
      lut_g[i] = 8'(i) ^ 8'h5a;
      lut_b[i] = 8'(i + 3);
      bus(1'b1, 32'h10, {8'h0, lut_r[i], lut_g[i], lut_b[i]});
    end
    rdchk("lut_ptr_wrap", 32'h0c, 32'h0);
    mask_v = 32'hf0_ff0f;
    bus(1'b1, 32'h04, mask_v);
    set_ctrl(32'h00);
    stream("lut_masked", 24);
    set_ctrl(32'h02);
    stream("index_mode", 24);
    give_verdict();
  end

  initial begin
    #2000000;
    $display("mismatch run_time expected finish seen timeout");
    bad_count++;
    give_verdict();
  end
endmodule
